// [inc/ulsie_map.svh]
// Register offsets, field positions, reset values and counts of the serial channel
`ifndef ULSIE_MAP_SVH
`define ULSIE_MAP_SVH
`define ULSIE_OFS_DATA      4'h0
`define ULSIE_OFS_IMASK     4'h1
`define ULSIE_OFS_LFMT      4'h2
`define ULSIE_OFS_LCOND     4'h3
`define ULSIE_OFS_DIVLO     4'h4
`define ULSIE_OFS_DIVHI     4'h5
`define ULSIE_OFS_NINE      4'h6
`define ULSIE_OFS_ENH       4'h7
`define ULSIE_OFS_MODE      4'h8
`define ULSIE_OFS_SPC0      4'h9
`define ULSIE_OFS_SPC3      4'hC
`define ULSIE_OFS_STOP2     4'hD
`define ULSIE_OFS_STOP1     4'hE
`define ULSIE_OFS_EVENT     4'hF
`define ULSIE_LFMT_RESET    8'h03
`define ULSIE_DIV_RESET     16'h0010
`define ULSIE_UNLOCK_VAL    8'hBF
`define ULSIE_LF_DLAB       7
`define ULSIE_LF_BREAK      6
`define ULSIE_LF_PAR_EN     3
`define ULSIE_LF_STOP       2
`define ULSIE_ENH_ON        4
`define ULSIE_ENH_STOP2     5
`define ULSIE_MODE_BYTE     0
`define ULSIE_MODE_750      1
`define ULSIE_MODE_GMASK    2
`define ULSIE_MODE_IR       3
`define ULSIE_QDEPTH        4
`define ULSIE_QDEPTH_W      3'h4
`endif

// [inc/ulsie_pkg.sv]
// Types shared by the serial channel line logic
package ulsie_pkg;
   typedef struct packed {
      logic       brk;
      logic       ferr;
      logic       perr;
      logic [8:0] data;
   } ulsie_rx_entry_t;

   typedef enum logic [2:0] {
      TX_IDLE  = 3'b000,
      TX_START = 3'b001,
      TX_DATA  = 3'b010,
      TX_PAR   = 3'b011,
      TX_STOP  = 3'b100
   } ulsie_tx_state_t;

   typedef enum logic [2:0] {
      RX_IDLE  = 3'b000,
      RX_START = 3'b001,
      RX_DATA  = 3'b010,
      RX_PAR   = 3'b011,
      RX_STOP  = 3'b100,
      RX_BRKW  = 3'b101
   } ulsie_rx_state_t;
endpackage : ulsie_pkg

// [logic/ulsie_channel.sv]
// Line format, line condition and interrupt mask logic of one serial channel
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ulsie_map.svh"

module ulsie_channel (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst,
   // Register port
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output var  logic [7:0] reg_rdata,
   // Serial line
   input  wire logic       serial_in,
   output var  logic       serial_out,
   // Event sources from neighbouring channel logic
   input  wire logic       modem_change,
   input  wire logic       rts_change,
   input  wire logic       cts_change,
   // Channel outputs
   output var  logic       irq,
   output var  logic       sleep_request
);
   logic [7:0]  line_format;
   logic [7:0]  interrupt_mask;
   logic [15:0] divisor;
   logic [7:0]  nine_bit_control;
   logic [7:0]  enhanced_features;
   logic [7:0]  mode_ctrl;
   logic [7:0]  spc [0:3];
   logic [7:0]  second_stop_char;
   logic [7:0]  stop_char;
   logic        overrun;
   logic        err_summary;
   logic        head_seen;
   logic        spc_event;

   // Receive queue
   ulsie_pkg::ulsie_rx_entry_t rxq [0:`ULSIE_QDEPTH-1];
   logic [1:0] rx_wp;
   logic [1:0] rx_rp;
   logic [2:0] rx_cnt;
   // Transmit queue
   logic [8:0] txq [0:`ULSIE_QDEPTH-1];
   logic [1:0] tx_wp;
   logic [1:0] tx_rp;
   logic [2:0] tx_cnt;

   // Configuration decode
   wire nine     = nine_bit_control[0];
   wire enh      = enhanced_features[`ULSIE_ENH_ON];
   wire byte_md  = mode_ctrl[`ULSIE_MODE_BYTE];
   wire par_en   = line_format[`ULSIE_LF_PAR_EN] & ~nine;
   wire [1:0] par_typ = line_format[5:4];
   wire [3:0] nbits = nine ? 4'h9 : {2'b00, line_format[1:0]} + 4'h5;
   // Stop length in half bits: 2, 3 for 5-bit, 4 otherwise
   wire [2:0] stop_halves = ~line_format[`ULSIE_LF_STOP] ? 3'h2 :
                            (!nine && line_format[1:0] == 2'b00) ? 3'h3 : 3'h4;
   wire [15:0] div_eff  = (divisor == 16'h0000) ? 16'h0001 : divisor;
   wire [15:0] half_div = (div_eff[15:1] == 15'h0000) ? 16'h0001 : {1'b0, div_eff[15:1]};
   wire [2:0] rx_cap    = byte_md ? 3'h1 : `ULSIE_QDEPTH_W;

   // Register access decode
   wire dlab   = line_format[`ULSIE_LF_DLAB];
   wire wr_at_data  = reg_wr && reg_addr == `ULSIE_OFS_DATA;
   wire rd_at_data  = reg_rd && reg_addr == `ULSIE_OFS_DATA;
   wire rd_at_lcond = reg_rd && reg_addr == `ULSIE_OFS_LCOND;
   wire rd_at_event = reg_rd && reg_addr == `ULSIE_OFS_EVENT;
   wire wr_divlo    = reg_wr && reg_addr == `ULSIE_OFS_DIVLO && dlab;
   wire wr_divhi    = reg_wr && reg_addr == `ULSIE_OFS_DIVHI && dlab;
   wire spc_wr      = reg_wr && reg_addr >= `ULSIE_OFS_SPC0 && reg_addr <= `ULSIE_OFS_SPC3;
   wire [1:0] spc_idx = 2'(reg_addr - `ULSIE_OFS_SPC0);

   // Receive queue status and transmit queue empty
   wire rx_empty = (rx_cnt == 3'h0);
   wire rx_full  = (rx_cnt >= rx_cap);
   ulsie_pkg::ulsie_rx_entry_t head;
   assign head = rxq[rx_rp];
   wire rx_pop   = rd_at_data && !rx_empty;
   wire hd_pe    = nine ? (!rx_empty && head.data[8]) : (!rx_empty && head.perr && !head_seen);
   wire hd_fe    = !rx_empty && head.ferr && !head_seen;
   wire hd_bi    = !rx_empty && head.brk && !head_seen;
   wire tx_empty = (tx_cnt == 3'h0);

   // Transmitter
   ulsie_pkg::ulsie_tx_state_t tx_st;
   logic [15:0] tx_tmr;
   logic [3:0]  tx_bit;
   logic [2:0]  tx_half;
   logic [8:0]  tx_sh;
   logic        tx_line;
   wire tx_tick  = (tx_tmr == 16'h0000);
   wire tx_load  = (tx_st == ulsie_pkg::TX_IDLE) && !tx_empty;
   wire tx_push  = wr_at_data && (tx_cnt < `ULSIE_QDEPTH_W);
   wire tx_idle  = tx_empty && (tx_st == ulsie_pkg::TX_IDLE);
   wire [8:0] tx_mask = 9'h1FF >> (4'h9 - nbits);
   wire tx_par   = par_typ[1] ? ~par_typ[0] : ^((tx_sh & tx_mask) ^ {8'h00, ~par_typ[0]});

   // Receiver
   ulsie_pkg::ulsie_rx_state_t rx_st;
   logic [15:0] rx_tmr;
   logic [3:0]  rx_bit;
   logic [8:0]  rx_sh;
   logic        rx_zero;
   logic        rx_pbit;
   wire rx_tick  = (rx_tmr == 16'h0000);
   wire [8:0] rx_data = rx_sh & tx_mask;
   wire rx_pexp  = par_typ[1] ? ~par_typ[0] : ^(rx_data ^ {8'h00, ~par_typ[0]});
   wire rx_perr  = par_en && (rx_pbit != rx_pexp);
   wire rx_done  = (rx_st == ulsie_pkg::RX_STOP) && rx_tick;
   wire rx_brk   = rx_done && rx_zero && !serial_in;
   wire rx_ferr  = rx_done && !serial_in && !rx_brk;
   wire rx_push  = rx_done && !rx_full;
   wire rx_ovr   = rx_done && rx_full;
   ulsie_pkg::ulsie_rx_entry_t rx_new;
   assign rx_new = '{brk: rx_brk, ferr: rx_ferr, perr: rx_perr && !rx_brk,
                     data: rx_brk ? 9'h000 : rx_data};
   wire rx_bad   = rx_brk || rx_ferr || (rx_perr && !nine);

   // Special character detection on each completed character that is pushed into the receive queue
   wire [7:0] rc = rx_data[7:0];
   wire spc_hit  = (rc == spc[0]) || (rc == spc[1]) || (rc == spc[2]) || (rc == spc[3]);
   wire nine_spc = nine && interrupt_mask[5] && spc_hit;
   wire enh_spc  = !nine && enh && interrupt_mask[5] &&
                   ((enhanced_features[3:0] != 4'h0 && rc == stop_char) ||
                    (enhanced_features[`ULSIE_ENH_STOP2] && rc == second_stop_char));
   wire spc_set  = rx_push && (nine_spc || enh_spc);

   // Interrupt sources
   wire src_rx   = interrupt_mask[0] && !rx_empty;
   wire src_tx   = interrupt_mask[1] && tx_empty;
   wire src_ms   = interrupt_mask[3] && modem_change;
   wire src_ls   = interrupt_mask[2] && (overrun || hd_pe || hd_fe || hd_bi);
   wire src_rts  = rts_change && (!enh || interrupt_mask[6]);
   wire src_cts  = cts_change && (!enh || interrupt_mask[7]);
   wire any_src  = src_rx || src_tx || src_ms || src_ls || spc_event || src_rts || src_cts;
   wire next_irq = mode_ctrl[`ULSIE_MODE_GMASK] && any_src;
   wire next_sleep = interrupt_mask[4] ||
                     (mode_ctrl[`ULSIE_MODE_750] && !nine && interrupt_mask[5]);

   // Read data selection
   wire [7:0] lcond = {err_summary, tx_idle, tx_empty, hd_bi, hd_fe, hd_pe, overrun, !rx_empty};
   logic [7:0] rd_mux;
   always_comb begin
      case (reg_addr)
         `ULSIE_OFS_DATA:  rd_mux = rx_empty ? 8'h00 : head.data[7:0];
         `ULSIE_OFS_IMASK: rd_mux = interrupt_mask;
         `ULSIE_OFS_LFMT:  rd_mux = line_format;
         `ULSIE_OFS_LCOND: rd_mux = lcond;
         `ULSIE_OFS_DIVLO: rd_mux = dlab ? divisor[7:0] : 8'h00;
         `ULSIE_OFS_DIVHI: rd_mux = dlab ? divisor[15:8] : 8'h00;
         `ULSIE_OFS_NINE:  rd_mux = nine_bit_control;
         `ULSIE_OFS_ENH:   rd_mux = enhanced_features;
         `ULSIE_OFS_MODE:  rd_mux = mode_ctrl;
         `ULSIE_OFS_STOP2: rd_mux = second_stop_char;
         `ULSIE_OFS_STOP1: rd_mux = stop_char;
         `ULSIE_OFS_EVENT: rd_mux = {7'h00, spc_event};
         default:          rd_mux = spc[spc_idx];
      endcase
   end

   // Register writes
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         line_format       <= `ULSIE_LFMT_RESET;
         interrupt_mask    <= 8'h00;
         divisor           <= `ULSIE_DIV_RESET;
         nine_bit_control  <= 8'h00;
         enhanced_features <= 8'h00;
         mode_ctrl         <= 8'h00;
         second_stop_char  <= 8'h00;
         stop_char         <= 8'h00;
      end else if (reg_wr) begin
         case (reg_addr)
            `ULSIE_OFS_LFMT: begin
               if (reg_wdata == `ULSIE_UNLOCK_VAL)
                  line_format <= {1'b1, line_format[6:0]};
               else
                  line_format <= reg_wdata;
            end
            `ULSIE_OFS_IMASK: interrupt_mask    <= reg_wdata;
            `ULSIE_OFS_NINE:  nine_bit_control  <= reg_wdata;
            `ULSIE_OFS_ENH:   enhanced_features <= reg_wdata;
            `ULSIE_OFS_MODE:  mode_ctrl         <= reg_wdata;
            `ULSIE_OFS_STOP2: second_stop_char  <= reg_wdata;
            `ULSIE_OFS_STOP1: stop_char         <= reg_wdata;
            default: begin
               if (wr_divlo)
                  divisor[7:0] <= reg_wdata;
               if (wr_divhi)
                  divisor[15:8] <= reg_wdata;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         spc[0] <= 8'h00;
         spc[1] <= 8'h00;
         spc[2] <= 8'h00;
         spc[3] <= 8'h00;
      end else if (spc_wr) begin
         spc[spc_idx] <= reg_wdata;
      end
   end

   // Sticky flags: a setting event in the clearing cycle wins
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         overrun     <= 1'b0;
         err_summary <= 1'b0;
         spc_event   <= 1'b0;
      end else begin
         overrun     <= rx_ovr || (overrun && !rd_at_lcond);
         err_summary <= !byte_md && ((rx_push && rx_bad) || (err_summary && !rd_at_lcond));
         spc_event   <= spc_set || (spc_event && !rd_at_event);
      end
   end

   // Head flags show once per character; a status read hides them until the next pop, except the nine-bit ninth bit in the pe position
   always_ff @(posedge sys_clk) begin
      if (rst)
         head_seen <= 1'b0;
      else if (rx_pop)
         head_seen <= 1'b0;
      else if (rd_at_lcond && !rx_empty)
         head_seen <= 1'b1;
   end

   // Receive queue storage
   always_ff @(posedge sys_clk) begin
      if (rx_push)
         rxq[rx_wp] <= rx_new;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rx_wp  <= 2'h0;
         rx_rp  <= 2'h0;
         rx_cnt <= 3'h0;
      end else begin
         if (rx_push)
            rx_wp <= rx_wp + 2'h1;
         if (rx_pop)
            rx_rp <= rx_rp + 2'h1;
         rx_cnt <= rx_cnt + {2'b00, rx_push} - {2'b00, rx_pop};
      end
   end

   // Transmit queue: writes to a full queue are dropped
   always_ff @(posedge sys_clk) begin
      if (tx_push)
         txq[tx_wp] <= {1'b0, reg_wdata};
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tx_wp  <= 2'h0;
         tx_rp  <= 2'h0;
         tx_cnt <= 3'h0;
      end else begin
         if (tx_push)
            tx_wp <= tx_wp + 2'h1;
         if (tx_load)
            tx_rp <= tx_rp + 2'h1;
         tx_cnt <= tx_cnt + {2'b00, tx_push} - {2'b00, tx_load};
      end
   end

   // Transmit sequencer; ninth bit of a nine-bit character is sent as zero
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tx_st   <= ulsie_pkg::TX_IDLE;
         tx_tmr  <= 16'h0000;
         tx_bit  <= 4'h0;
         tx_half <= 3'h0;
         tx_sh   <= 9'h000;
         tx_line <= 1'b1;
      end else begin
         case (tx_st)
            ulsie_pkg::TX_IDLE: begin
               tx_line <= 1'b1;
               if (tx_load) begin
                  tx_sh   <= txq[tx_rp];
                  tx_line <= 1'b0;
                  tx_tmr  <= div_eff - 16'h0001;
                  tx_st   <= ulsie_pkg::TX_START;
               end
            end
            ulsie_pkg::TX_START: begin
               tx_tmr <= tx_tick ? div_eff - 16'h0001 : tx_tmr - 16'h0001;
               if (tx_tick) begin
                  tx_line <= tx_sh[0];
                  tx_bit  <= 4'h1;
                  tx_st   <= ulsie_pkg::TX_DATA;
               end
            end
            ulsie_pkg::TX_DATA: begin
               tx_tmr <= tx_tick ? div_eff - 16'h0001 : tx_tmr - 16'h0001;
               if (tx_tick) begin
                  tx_bit <= tx_bit + 4'h1;
                  if (tx_bit < nbits) begin
                     tx_line <= tx_sh[tx_bit];
                  end else if (par_en) begin
                     tx_line <= tx_par;
                     tx_st   <= ulsie_pkg::TX_PAR;
                  end else begin
                     tx_line <= 1'b1;
                     tx_half <= stop_halves;
                     tx_tmr  <= half_div - 16'h0001;
                     tx_st   <= ulsie_pkg::TX_STOP;
                  end
               end
            end
            ulsie_pkg::TX_PAR: begin
               tx_tmr <= tx_tick ? half_div - 16'h0001 : tx_tmr - 16'h0001;
               if (tx_tick) begin
                  tx_line <= 1'b1;
                  tx_half <= stop_halves;
                  tx_st   <= ulsie_pkg::TX_STOP;
               end
            end
            ulsie_pkg::TX_STOP: begin
               tx_tmr <= tx_tick ? half_div - 16'h0001 : tx_tmr - 16'h0001;
               if (tx_tick) begin
                  tx_half <= tx_half - 3'h1;
                  if (tx_half == 3'h1)
                     tx_st <= ulsie_pkg::TX_IDLE;
               end
            end
            default: tx_st <= ulsie_pkg::TX_IDLE;
         endcase
      end
   end

   // Receive sequencer; a character is still framed when the queue is full
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rx_st   <= ulsie_pkg::RX_IDLE;
         rx_tmr  <= 16'h0000;
         rx_bit  <= 4'h0;
         rx_sh   <= 9'h000;
         rx_zero <= 1'b0;
         rx_pbit <= 1'b0;
      end else begin
         rx_tmr <= rx_tick ? div_eff - 16'h0001 : rx_tmr - 16'h0001;
         case (rx_st)
            ulsie_pkg::RX_IDLE: begin
               if (!serial_in) begin
                  rx_tmr <= half_div - 16'h0001;
                  rx_st  <= ulsie_pkg::RX_START;
               end
            end
            ulsie_pkg::RX_START: begin
               if (rx_tick) begin
                  rx_st   <= serial_in ? ulsie_pkg::RX_IDLE : ulsie_pkg::RX_DATA;
                  rx_bit  <= 4'h0;
                  rx_sh   <= 9'h000;
                  rx_zero <= 1'b1;
                  rx_pbit <= 1'b0;
               end
            end
            ulsie_pkg::RX_DATA: begin
               if (rx_tick) begin
                  rx_sh[rx_bit] <= serial_in;
                  rx_zero <= rx_zero && !serial_in;
                  rx_bit  <= rx_bit + 4'h1;
                  if (rx_bit == nbits - 4'h1)
                     rx_st <= par_en ? ulsie_pkg::RX_PAR : ulsie_pkg::RX_STOP;
               end
            end
            ulsie_pkg::RX_PAR: begin
               if (rx_tick) begin
                  rx_pbit <= serial_in;
                  rx_zero <= rx_zero && !serial_in;
                  rx_st   <= ulsie_pkg::RX_STOP;
               end
            end
            ulsie_pkg::RX_STOP: begin
               if (rx_tick) begin
                  rx_bit  <= 4'h0;
                  rx_sh   <= 9'h000;
                  rx_zero <= 1'b1;
                  rx_pbit <= 1'b0;
                  if (rx_brk)
                     rx_st <= ulsie_pkg::RX_BRKW;
                  else if (rx_ferr)
                     rx_st <= ulsie_pkg::RX_DATA;
                  else
                     rx_st <= ulsie_pkg::RX_IDLE;
               end
            end
            ulsie_pkg::RX_BRKW: begin
               if (serial_in)
                  rx_st <= ulsie_pkg::RX_IDLE;
            end
            default: rx_st <= ulsie_pkg::RX_IDLE;
         endcase
      end
   end

   // Output flops; the break bit of line_format holds serial_out low
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         serial_out    <= 1'b1;
         reg_rdata     <= 8'h00;
         irq           <= 1'b0;
         sleep_request <= 1'b0;
      end else begin
         serial_out    <= tx_line && !line_format[`ULSIE_LF_BREAK];
         reg_rdata     <= reg_rd ? rd_mux : 8'h00;
         irq           <= next_irq;
         sleep_request <= next_sleep;
      end
   end
endmodule : ulsie_channel
`default_nettype wire

// [verification/ulsie_terminal.sv]
// Remote serial terminal model driving the channel's serial input
`timescale 1ns/1ps
`default_nettype none
module ulsie_terminal #(parameter int DIV = 4) (
   // Clock
   input wire logic sys_clk,
   // Line toward the channel, idle high
   output var logic line
);
   initial line = 1'b1;
   task automatic bit_out(input logic b, input int n);
      line <= b;
      repeat (n * DIV) @(posedge sys_clk);
   endtask : bit_out
   // LSB first, optional parity bit, one stop bit
   task automatic send(input logic [7:0] d, input logic pen, input logic pb);
      @(posedge sys_clk);
      bit_out(1'b0, 1);
      for (int i = 0; i < 8; i++) bit_out(d[i], 1);
      if (pen) bit_out(pb, 1);
      bit_out(1'b1, 1);
   endtask : send
   // Held well past one character so it reads as a break, not data
   task automatic hold_low(input int bits);
      @(posedge sys_clk);
      bit_out(1'b0, bits);
      line <= 1'b1;
   endtask : hold_low
endmodule : ulsie_terminal
`default_nettype wire

// [verification/ulsie_channel_monitor.sv]
// Port checker of the serial channel line logic
`timescale 1ns/1ps
`default_nettype none
`include "ulsie_map.svh"
module ulsie_channel_monitor (
   // Clock and reset
   input wire logic       sys_clk,
   input wire logic       rst,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   // Serial line and events
   input wire logic       serial_in,
   input wire logic       serial_out,
   input wire logic       modem_change,
   input wire logic       rts_change,
   input wire logic       cts_change,
   input wire logic       irq,
   input wire logic       sleep_request
);
   // Shadows follow writes on the same edge as the design registers
   logic [7:0] lfmt;
   logic [7:0] imask;
   logic [3:0] ctl;
   logic [1:0] brk_age;
   wire logic wr_lf = reg_wr && reg_addr == `ULSIE_OFS_LFMT;
   wire logic lc_rd = reg_rd && reg_addr == `ULSIE_OFS_LCOND;
   wire logic wr_en = reg_wr && reg_addr == `ULSIE_OFS_ENH;
   wire logic wr_nb = reg_wr && reg_addr == `ULSIE_OFS_NINE;
   wire logic wr_md = reg_wr && reg_addr == `ULSIE_OFS_MODE;
   wire logic [3:0] next_ctl = {wr_en ? reg_wdata[4] : ctl[3], wr_nb ? reg_wdata[0] : ctl[2],
                                wr_md ? reg_wdata[2:1] : ctl[1:0]};
   wire logic [1:0] next_brk = !lfmt[6] ? 2'h0 : (brk_age == 2'h3 ? 2'h3 : brk_age + 2'h1);
   wire logic mod_on = ctl[1] & imask[3] & modem_change;
   wire logic rts_on = ctl[1] & !ctl[3] & rts_change;
   wire logic quiet = ctl[3] & (imask == 8'h00);
   wire logic alt_sl = ctl[0] & !ctl[2] & imask[5];
   wire logic gm = ctl[1];
   wire logic sl = imask[4];
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         lfmt <= `ULSIE_LFMT_RESET;
         imask <= 8'h00;
         ctl <= 4'h0;
         brk_age <= 2'h0;
      end else begin
         if (wr_lf) lfmt <= (reg_wdata == `ULSIE_UNLOCK_VAL) ? {1'b1, lfmt[6:0]} : reg_wdata;
         if (reg_wr && reg_addr == `ULSIE_OFS_IMASK) imask <= reg_wdata;
         ctl <= next_ctl;
         brk_age <= next_brk;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_break_low: assert property (brk_age == 2'h3 |-> !serial_out) else $error("break not on line");
   a_divisor_gate: assert property (reg_rd && !lfmt[7] && reg_addr[3:1] == 3'h2 |=> reg_rdata == 8'h00)
      else $error("divisor readable while locked");
   a_flags_clear: assert property (lc_rd ##1 lc_rd && reg_rdata[0] |=> reg_rdata[4:3] == 2'h0)
      else $error("head flags survive status read");
   a_idle_empty: assert property ($past(lc_rd) && reg_rdata[6] |-> reg_rdata[5]) else $error("idle with queue");
   a_irq_global: assert property (!$past(gm) |-> !irq) else $error("irq with global mask off");
   a_irq_quiet: assert property ($past(quiet) |-> !irq) else $error("irq with all masks off");
   a_modem_irq: assert property ($past(mod_on) |-> irq) else $error("modem irq missing");
   a_rts_always: assert property ($past(rts_on) |-> irq) else $error("rts irq missing");
   a_sleep_req: assert property ($past(sl, 2) && $past(sl) |-> sleep_request) else $error("no sleep");
   a_sleep_alt: assert property ($past(alt_sl, 2) && $past(alt_sl) |-> sleep_request) else $error("no sleep");
endmodule : ulsie_channel_monitor
bind ulsie_channel ulsie_channel_monitor i_mon (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_in(serial_in),
   .serial_out(serial_out), .modem_change(modem_change), .rts_change(rts_change), .cts_change(cts_change),
   .irq(irq), .sleep_request(sleep_request));
`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench of the serial channel line logic
`timescale 1ns/1ps
`default_nettype none
`include "ulsie_map.svh"
module testbench;
   localparam int DIV = 4;
   logic       sys_clk = 1'b0;
   logic       rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic       modem_change = 1'b0;
   logic       rts_change = 1'b0;
   logic       cts_change = 1'b0;
   logic [7:0] reg_rdata;
   logic       serial_in;
   logic       serial_out;
   logic       irq;
   logic       sleep_request;
   logic [7:0] v;
   int         miscompares = 0;
   int         total_checks = 0;
   int         cycles = 0;
   always #25 sys_clk = ~sys_clk;
   ulsie_channel i_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_in(serial_in), .serial_out(serial_out),
      .modem_change(modem_change), .rts_change(rts_change), .cts_change(cts_change), .irq(irq),
      .sleep_request(sleep_request));
   ulsie_terminal #(.DIV(DIV)) i_term (.sys_clk(sys_clk), .line(serial_in));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk1(input logic got, input logic exp);
      chk({7'h00, got}, {7'h00, exp});
   endtask : chk1
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd
   task automatic settle(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : settle
   task automatic t_regs;
      rd(`ULSIE_OFS_LCOND);
      chk(v, 8'h60);
      rd(`ULSIE_OFS_DIVLO);
      chk(v, 8'h00);
      wr(`ULSIE_OFS_LFMT, 8'hBF);
      rd(`ULSIE_OFS_LFMT);
      chk(v, 8'h83);
      rd(`ULSIE_OFS_DIVLO);
      chk(v, 8'h10);
      wr(`ULSIE_OFS_DIVLO, 8'(DIV));
      wr(`ULSIE_OFS_LFMT, 8'h03);
      rd(`ULSIE_OFS_DIVLO);
      chk(v, 8'h00);
      wr(`ULSIE_OFS_DIVLO, 8'h77);
      wr(`ULSIE_OFS_LFMT, 8'hBF);
      rd(`ULSIE_OFS_DIVLO);
      chk(v, 8'(DIV));
      wr(`ULSIE_OFS_LFMT, 8'h03);
   endtask : t_regs
   task automatic t_tx;
      logic [9:0] got;
      wr(`ULSIE_OFS_DATA, 8'h5A);
      rd(`ULSIE_OFS_LCOND);
      chk(v & 8'h40, 8'h00);
      for (int i = 0; i < 20 && serial_out; i++) settle(1);
      settle(DIV / 2);
      for (int i = 0; i < 10; i++) begin
         got[i] = serial_out;
         settle(DIV);
      end
      chk(got[8:1], 8'h5A);
      chk({6'h00, got[9], got[0]}, 8'h02);
      rd(`ULSIE_OFS_LCOND);
      chk(v & 8'h60, 8'h60);
      wr(`ULSIE_OFS_LFMT, 8'h43);
      settle(4);
      chk1(serial_out, 1'b0);
      wr(`ULSIE_OFS_LFMT, 8'h03);
   endtask : t_tx
   task automatic t_overrun;
      for (int i = 0; i < 5; i++) i_term.send(8'h10 + 8'(i), 1'b0, 1'b0);
      rd(`ULSIE_OFS_LCOND);
      chk(v & 8'h03, 8'h03);
      rd(`ULSIE_OFS_LCOND);
      chk(v & 8'h02, 8'h00);
      for (int i = 0; i < 4; i++) begin
         rd(`ULSIE_OFS_DATA);
         chk(v, 8'h10 + 8'(i));
      end
      rd(`ULSIE_OFS_LCOND);
      chk(v & 8'h01, 8'h00);
   endtask : t_overrun
   task automatic t_break;
      i_term.hold_low(12);
      settle(DIV);
      rd(`ULSIE_OFS_LCOND);
      chk(v & 8'h91, 8'h91);
      rd(`ULSIE_OFS_DATA);
      chk(v, 8'h00);
   endtask : t_break
   task automatic t_parity;
      wr(`ULSIE_OFS_LFMT, 8'h1B);
      i_term.send(8'hA5, 1'b1, 1'b1);
      // Two status reads back to back: the second must see the flags gone
      @(posedge sys_clk);
      reg_addr <= `ULSIE_OFS_LCOND;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      #1 chk(reg_rdata & 8'h85, 8'h85);
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata & 8'h84, 8'h00);
      rd(`ULSIE_OFS_DATA);
      chk(v, 8'hA5);
   endtask : t_parity
   task automatic t_irq;
      wr(`ULSIE_OFS_MODE, 8'h04);
      wr(`ULSIE_OFS_IMASK, 8'h08);
      modem_change <= 1'b1;
      settle(3);
      chk1(irq, 1'b1);
      wr(`ULSIE_OFS_IMASK, 8'h00);
      settle(3);
      chk1(irq, 1'b0);
      @(posedge sys_clk) rts_change <= 1'b1;
      settle(3);
      chk1(irq, 1'b1);
      wr(`ULSIE_OFS_ENH, 8'h10);
      settle(3);
      chk1(irq, 1'b0);
      wr(`ULSIE_OFS_IMASK, 8'h80);
      cts_change <= 1'b1;
      settle(3);
      chk1(irq, 1'b1);
      wr(`ULSIE_OFS_ENH, 8'h00);
      wr(`ULSIE_OFS_MODE, 8'h00);
      settle(3);
      chk1(irq, 1'b0);
      wr(`ULSIE_OFS_IMASK, 8'h10);
      settle(3);
      chk1(sleep_request, 1'b1);
      wr(`ULSIE_OFS_MODE, 8'h02);
      wr(`ULSIE_OFS_IMASK, 8'h20);
      settle(3);
      chk1(sleep_request, 1'b1);
   endtask : t_irq
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : conclude
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         conclude();
      end
   end
   initial begin
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      t_regs();
      t_tx();
      t_overrun();
      t_break();
      t_parity();
      t_irq();
      conclude();
   end
endmodule : testbench
`default_nettype wire
